// ==== common/asc_pkg.sv ====
package asc_pkg;

  // ==================================================
  // register indices (byte address = index * 4)
  localparam logic [7:0] SETUP_IDX_FIRST = 8'h19;
  localparam logic [7:0] SETUP_IDX_LAST = 8'h20;
  localparam logic [7:0] CHAN_IDX_BASE = 8'h30;
  localparam logic [7:0] STATUS_IDX = 8'h50;

  // ==================================================
  // reset values
  localparam logic [15:0] SETUP_RESET = 16'h0000;
  localparam logic [10:0] CHAN_RESET = 11'h000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ==================================================
  // setup register fields
  localparam int SRC_B_LSB = 13;
  localparam int SRC_A_LSB = 10;
  localparam int BURN_LSB = 8;
  localparam int REFP_BIT = 7;
  localparam int REFN_BIT = 6;
  localparam int REFSEL_LSB = 4;
  localparam int GAIN_LSB = 1;
  localparam int BYP_BIT = 0;

  // ==================================================
  // channel register fields
  localparam int CH_PIN_A_LSB = 0;
  localparam int CH_PIN_B_LSB = 4;
  localparam int CH_SETUP_LSB = 8;

  // ==================================================
  // status register fields
  localparam int ST_CHAN_LSB = 0;
  localparam int ST_SETUP_LSB = 4;
  localparam int ST_VALID_BIT = 8;

  localparam logic [7:0] GAIN_UNITY = 8'h01;

  typedef enum logic [1:0] {
    REF_EXT_A = 2'h0,
    REF_EXT_B = 2'h1,
    REF_INTERNAL = 2'h2,
    REF_SUPPLY = 2'h3
  } asc_ref_t;

  typedef enum logic [1:0] {
    K_NONE = 2'h0,
    K_SETUP = 2'h1,
    K_CHAN = 2'h2,
    K_STAT = 2'h3
  } asc_kind_t;

endpackage : asc_pkg

// ==== common/asc_setup_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface asc_setup_if;
  logic [15:0] word;
  logic [2:0] src_a_mag;
  logic [2:0] src_b_mag;
  logic [1:0] burnout;
  logic refp;
  logic refn;
  asc_pkg::asc_ref_t ref_sel;
  logic [2:0] gain_code;
  logic bypass;
  logic [7:0] gain;

  modport bank (
    output word,
    input src_a_mag, src_b_mag, burnout, refp, refn, ref_sel, gain_code, bypass, gain
  );
  modport dec (
    input word,
    output src_a_mag, src_b_mag, burnout, refp, refn, ref_sel, gain_code, bypass, gain
  );
endinterface : asc_setup_if

`default_nettype wire

// ==== logic/asc_setup_decode.sv ====
`timescale 1ns/10ps
`default_nettype none

module asc_setup_decode (
  asc_setup_if.dec sif
);

  // ==================================================
  // effective gain
  function automatic logic [7:0] gain_of(input logic [2:0] code, input logic byp);
    logic [7:0] g;
    g = asc_pkg::GAIN_UNITY << code;
    if (byp) begin
      g = asc_pkg::GAIN_UNITY;
    end
    return g;
  endfunction : gain_of

  // ==================================================
  // field split
  assign sif.src_b_mag = sif.word[asc_pkg::SRC_B_LSB +: 3];
  assign sif.src_a_mag = sif.word[asc_pkg::SRC_A_LSB +: 3];
  assign sif.burnout = sif.word[asc_pkg::BURN_LSB +: 2];
  assign sif.refp = sif.word[asc_pkg::REFP_BIT];
  assign sif.refn = sif.word[asc_pkg::REFN_BIT];
  assign sif.ref_sel = asc_pkg::asc_ref_t'(sif.word[asc_pkg::REFSEL_LSB +: 2]);
  assign sif.gain_code = sif.word[asc_pkg::GAIN_LSB +: 3];
  assign sif.bypass = sif.word[asc_pkg::BYP_BIT];
  assign sif.gain = gain_of(sif.word[asc_pkg::GAIN_LSB +: 3], sif.word[asc_pkg::BYP_BIT]);

endmodule : asc_setup_decode

`default_nettype wire

// ==== logic/asc_setup_bank.sv ====
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module asc_setup_bank #(
  parameter int ADDR_W = 12,
  parameter int NUM_CH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] active_chan,
  input wire logic chan_change,
  output logic [2:0] excite_src_a_magnitude,
  output logic [2:0] excite_src_b_magnitude,
  output logic [3:0] excite_src_a_pin_select,
  output logic [3:0] excite_src_b_pin_select,
  output logic [1:0] burnout_code,
  output logic ref_pos_buffer_en,
  output logic ref_neg_buffer_en,
  output asc_pkg::asc_ref_t ref_select,
  output logic [2:0] amp_gain_code,
  output logic amp_bypass,
  output logic [7:0] amp_gain
);

  // ==================================================
  // elaboration checks
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 10 and 32");
  end
  if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 16");
  end

  // ==================================================
  // storage
  logic [15:0] setup_reg [8];
  logic [10:0] chan_reg [NUM_CH];
  logic [3:0] applied_chan_reg;
  logic [2:0] applied_setup_reg;
  logic applied_valid_reg;

  // ==================================================
  // address decode
  function automatic asc_pkg::asc_kind_t kind_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] w;
    asc_pkg::asc_kind_t k;
    w = a[ADDR_W-1:2];
    k = asc_pkg::K_NONE;
    if (a[1:0] != 2'h0) begin
      k = asc_pkg::K_NONE;
    end else if (w >= (ADDR_W-2)'(asc_pkg::SETUP_IDX_FIRST) && w <= (ADDR_W-2)'(asc_pkg::SETUP_IDX_LAST)) begin
      k = asc_pkg::K_SETUP;
    end else if (w >= (ADDR_W-2)'(asc_pkg::CHAN_IDX_BASE)
                 && w < (ADDR_W-2)'(asc_pkg::CHAN_IDX_BASE) + (ADDR_W-2)'(NUM_CH)) begin
      k = asc_pkg::K_CHAN;
    end else if (w == (ADDR_W-2)'(asc_pkg::STATUS_IDX)) begin
      k = asc_pkg::K_STAT;
    end
    return k;
  endfunction : kind_of

  function automatic logic [3:0] sub_of(input logic [ADDR_W-1:0] a, input asc_pkg::asc_kind_t k);
    logic [ADDR_W-3:0] w;
    logic [3:0] s;
    w = a[ADDR_W-1:2];
    s = 4'h0;
    if (k == asc_pkg::K_SETUP) begin
      s = 4'(w - (ADDR_W-2)'(asc_pkg::SETUP_IDX_FIRST));
    end else if (k == asc_pkg::K_CHAN) begin
      s = 4'(w - (ADDR_W-2)'(asc_pkg::CHAN_IDX_BASE));
    end
    return s;
  endfunction : sub_of

  // ==================================================
  // apb handshake
  asc_pkg::asc_kind_t acc_kind;
  logic [3:0] acc_sub;
  logic setup_phase;
  logic access_done;
  logic wr_fire;

  assign acc_kind = kind_of(paddr);
  assign acc_sub = sub_of(paddr, acc_kind);
  assign pready = pclk_en;
  assign pslverr = psel && penable && (acc_kind == asc_pkg::K_NONE);
  assign setup_phase = pclk_en && psel && !penable;
  assign access_done = pclk_en && psel && penable;
  assign wr_fire = access_done && pwrite && (acc_kind != asc_pkg::K_NONE);

  // ==================================================
  // setup register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        setup_reg[i] <= asc_pkg::SETUP_RESET;
      end
    end else if (wr_fire && acc_kind == asc_pkg::K_SETUP) begin
      if (pstrb[0]) begin
        setup_reg[acc_sub[2:0]][7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        setup_reg[acc_sub[2:0]][15:8] <= pwdata[15:8];
      end
    end
  end

  // ==================================================
  // channel register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        chan_reg[i] <= asc_pkg::CHAN_RESET;
      end
    end else if (wr_fire && acc_kind == asc_pkg::K_CHAN) begin
      if (pstrb[0]) begin
        chan_reg[acc_sub][7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        chan_reg[acc_sub][10:8] <= pwdata[10:8];
      end
    end
  end

  // ==================================================
  // read data
  logic [31:0] rd_next;

  always_comb begin
    rd_next = 32'h0000_0000;
    if (acc_kind == asc_pkg::K_SETUP) begin
      rd_next[15:0] = setup_reg[acc_sub[2:0]];
    end else if (acc_kind == asc_pkg::K_CHAN) begin
      rd_next[10:0] = chan_reg[acc_sub];
    end else if (acc_kind == asc_pkg::K_STAT) begin
      rd_next[asc_pkg::ST_CHAN_LSB +: 4] = applied_chan_reg;
      rd_next[asc_pkg::ST_SETUP_LSB +: 3] = applied_setup_reg;
      rd_next[asc_pkg::ST_VALID_BIT] = applied_valid_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= asc_pkg::RDATA_RESET;
    end else if (setup_phase) begin
      prdata <= pwrite ? asc_pkg::RDATA_RESET : rd_next;
    end
  end

  // ==================================================
  // active setup selection
  logic chan_ok;
  logic apply;
  logic [10:0] sel_chan;
  logic [2:0] sel_setup;

  assign chan_ok = 32'(active_chan) < NUM_CH;
  assign apply = pclk_en && chan_change && chan_ok;
  assign sel_chan = chan_ok ? chan_reg[active_chan] : asc_pkg::CHAN_RESET;
  assign sel_setup = sel_chan[asc_pkg::CH_SETUP_LSB +: 3];

  asc_setup_if sif ();

  assign sif.word = setup_reg[sel_setup];

  asc_setup_decode u_dec (
    .sif(sif)
  );

  // ==================================================
  // front-end outputs, updated at channel change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      excite_src_a_magnitude <= 3'h0;
      excite_src_b_magnitude <= 3'h0;
      burnout_code <= 2'h0;
      ref_pos_buffer_en <= 1'b0;
      ref_neg_buffer_en <= 1'b0;
      ref_select <= asc_pkg::REF_EXT_A;
      amp_gain_code <= 3'h0;
      amp_bypass <= 1'b0;
      amp_gain <= asc_pkg::GAIN_UNITY;
    end else if (apply) begin
      excite_src_a_magnitude <= sif.src_a_mag;
      excite_src_b_magnitude <= sif.src_b_mag;
      burnout_code <= sif.burnout;
      ref_pos_buffer_en <= sif.refp;
      ref_neg_buffer_en <= sif.refn;
      ref_select <= sif.ref_sel;
      amp_gain_code <= sif.gain_code;
      amp_bypass <= sif.bypass;
      amp_gain <= sif.gain;
    end
  end

  // ==================================================
  // pin routing, updated at channel change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      excite_src_a_pin_select <= 4'h0;
      excite_src_b_pin_select <= 4'h0;
    end else if (apply) begin
      excite_src_a_pin_select <= sel_chan[asc_pkg::CH_PIN_A_LSB +: 4];
      excite_src_b_pin_select <= sel_chan[asc_pkg::CH_PIN_B_LSB +: 4];
    end
  end

  // ==================================================
  // applied channel status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_chan_reg <= 4'h0;
      applied_setup_reg <= 3'h0;
      applied_valid_reg <= 1'b0;
    end else if (apply) begin
      applied_chan_reg <= active_chan;
      applied_setup_reg <= sel_setup;
      applied_valid_reg <= 1'b1;
    end
  end

  // ==================================================
  // assertions
  property p_setup_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && acc_kind == asc_pkg::K_SETUP && pstrb[1:0] == 2'h3)
      |=> setup_reg[$past(acc_sub[2:0])] == $past(pwdata[15:0]);
  endproperty
  a_setup_write: assert property (p_setup_write) else $error("setup write not stored");

  property p_setup_read;
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && acc_kind == asc_pkg::K_SETUP)
      |=> prdata == {16'h0000, setup_reg[$past(acc_sub[2:0])]};
  endproperty
  a_setup_read: assert property (p_setup_read) else $error("setup read back wrong");

  property p_unmapped_read;
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && acc_kind == asc_pkg::K_NONE) |=> prdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_frozen;
    @(posedge pclk) disable iff (!presetn)
    !pclk_en |=> $stable(prdata) && $stable(applied_valid_reg) && $stable(amp_bypass);
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved while clock enable low");

  property p_status_setup;
    @(posedge pclk) disable iff (!presetn)
    apply |=> applied_setup_reg == $past(sel_setup) && applied_chan_reg == $past(active_chan);
  endproperty
  a_status_setup: assert property (p_status_setup) else $error("applied setup not recorded");

  property p_src_b;
    @(posedge pclk) disable iff (!presetn)
    apply |=> excite_src_b_magnitude == $past(setup_reg[sel_setup][15:13]);
  endproperty
  a_src_b: assert property (p_src_b) else $error("source b magnitude wrong");

  property p_src_a;
    @(posedge pclk) disable iff (!presetn)
    apply |=> excite_src_a_magnitude == $past(setup_reg[sel_setup][12:10]);
  endproperty
  a_src_a: assert property (p_src_a) else $error("source a magnitude wrong");

  property p_burnout;
    @(posedge pclk) disable iff (!presetn)
    apply |=> burnout_code == $past(setup_reg[sel_setup][9:8]);
  endproperty
  a_burnout: assert property (p_burnout) else $error("burnout code wrong");

  property p_refp;
    @(posedge pclk) disable iff (!presetn)
    apply |=> ref_pos_buffer_en == $past(setup_reg[sel_setup][7]);
  endproperty
  a_refp: assert property (p_refp) else $error("positive buffer enable wrong");

  property p_refn;
    @(posedge pclk) disable iff (!presetn)
    apply |=> ref_neg_buffer_en == $past(setup_reg[sel_setup][6]);
  endproperty
  a_refn: assert property (p_refn) else $error("negative buffer enable wrong");

  property p_refsel;
    @(posedge pclk) disable iff (!presetn)
    apply |=> ref_select == $past(setup_reg[sel_setup][5:4]);
  endproperty
  a_refsel: assert property (p_refsel) else $error("reference select wrong");

  property p_gain;
    @(posedge pclk) disable iff (!presetn)
    (apply && !setup_reg[sel_setup][0])
      |=> amp_gain == (8'h01 << $past(setup_reg[sel_setup][3:1])) && !amp_bypass;
  endproperty
  a_gain: assert property (p_gain) else $error("gain not two to the code");

  property p_bypass;
    @(posedge pclk) disable iff (!presetn)
    amp_bypass |-> amp_gain == 8'h01;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass gain not unity");

  property p_pins;
    @(posedge pclk) disable iff (!presetn)
    apply |=> excite_src_a_pin_select == $past(sel_chan[3:0])
      && excite_src_b_pin_select == $past(sel_chan[7:4]);
  endproperty
  a_pins: assert property (p_pins) else $error("pin selectors wrong");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    !apply |=> $stable(amp_gain) && $stable(excite_src_a_magnitude)
      && $stable(excite_src_b_pin_select) && $stable(ref_select);
  endproperty
  a_hold: assert property (p_hold) else $error("front end changed without channel change");

endmodule : asc_setup_bank

`default_nettype wire

// ==== testbench/adc_setup_config_bank_bench.sv ====
`timescale 1ns/10ps
`default_nettype none

module adc_setup_config_bank_bench;
  // ==================================================
  // signals
  logic pclk;
  logic presetn;
  logic pclk_en;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [3:0] active_chan;
  logic chan_change;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] src_a_mag;
  logic [2:0] src_b_mag;
  logic [3:0] src_a_pin;
  logic [3:0] src_b_pin;
  logic [1:0] burnout_code;
  logic refp;
  logic refn;
  asc_pkg::asc_ref_t ref_select;
  logic [2:0] gain_code;
  logic bypass;
  logic [7:0] amp_gain;
  int failures;
  int check_count;

  asc_setup_bank #(.ADDR_W(12), .NUM_CH(16)) dut (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .active_chan(active_chan), .chan_change(chan_change),
    .excite_src_a_magnitude(src_a_mag), .excite_src_b_magnitude(src_b_mag),
    .excite_src_a_pin_select(src_a_pin), .excite_src_b_pin_select(src_b_pin),
    .burnout_code(burnout_code), .ref_pos_buffer_en(refp), .ref_neg_buffer_en(refn),
    .ref_select(ref_select), .amp_gain_code(gain_code), .amp_bypass(bypass), .amp_gain(amp_gain)
  );

  // ==================================================
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end

  // ==================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] setup_addr(input int n);
    return 12'((asc_pkg::SETUP_IDX_FIRST + n) * 4);
  endfunction : setup_addr

  function automatic logic [11:0] chan_addr(input int n);
    return 12'((asc_pkg::CHAN_IDX_BASE + n) * 4);
  endfunction : chan_addr

  function automatic logic [15:0] fe_val(input logic [2:0] n);
    return {n, ~n, n[1:0], n[0], ~n[0], ~n[1:0], n, 1'b0};
  endfunction : fe_val

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, s, rd, er);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0000_0000, 4'hF, rd, er);
    chk(rd, exp);
    chk(er, 32'h0);
  endtask : rdchk

  task automatic apply(input logic [3:0] k);
    @(posedge pclk);
    active_chan <= k;
    chan_change <= 1'b1;
    @(posedge pclk);
    chan_change <= 1'b0;
    @(negedge pclk);
  endtask : apply

  task automatic fe_chk(input logic [15:0] v, input logic [3:0] pa, input logic [3:0] pb);
    chk(src_b_mag, v[15:13]);
    chk(src_a_mag, v[12:10]);
    chk(burnout_code, v[9:8]);
    chk(refp, v[7]);
    chk(refn, v[6]);
    chk(ref_select, v[5:4]);
    chk(gain_code, v[3:1]);
    chk(bypass, v[0]);
    chk(amp_gain, v[0] ? 32'h1 : (32'h1 << v[3:1]));
    chk(src_a_pin, pa);
    chk(src_b_pin, pb);
  endtask : fe_chk

  // ==================================================
  // scenarios
  task automatic t_reset;
    fe_chk(16'h0000, 4'h0, 4'h0);
    for (int n = 0; n < 8; n++) rdchk(setup_addr(n), 32'h0000_0000);
  endtask : t_reset

  task automatic t_rw;
    for (int n = 0; n < 8; n++) wr(setup_addr(n), 32'hFFFF_0000 | (32'h1111 * n ^ 32'hA5C3), 4'hF);
    for (int n = 0; n < 8; n++) rdchk(setup_addr(n), 32'h1111 * n ^ 32'hA5C3);
    wr(setup_addr(2), 32'h0000_FFFF, 4'hF);
    wr(setup_addr(2), 32'h0000_0000, 4'h1);
    rdchk(setup_addr(2), 32'h0000_FF00);
  endtask : t_rw

  task automatic t_err;
    logic [31:0] rd;
    logic er;
    apb(1'b0, 12'((asc_pkg::SETUP_IDX_LAST + 1) * 4), 32'h0, 4'hF, rd, er);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, setup_addr(0) + 12'h001, 32'h0000_1234, 4'hF, rd, er);
    chk(er, 32'h1);
    rdchk(setup_addr(0), 32'h0000_A5C3);
  endtask : t_err

  task automatic t_frontend;
    for (int n = 0; n < 8; n++) begin
      wr(setup_addr(n), {16'h0000, fe_val(3'(n))}, 4'h3);
      wr(chan_addr(n), {21'h0, 3'(n), 4'(15 - n), 4'(n)}, 4'h3);
      apply(4'(n));
      fe_chk(fe_val(3'(n)), 4'(n), 4'(15 - n));
    end
    wr(chan_addr(9), {21'h0, 3'h2, 8'h00}, 4'h3);
    apply(4'h9);
    fe_chk(fe_val(3'h2), 4'h0, 4'h0);
    rdchk(chan_addr(9), 32'h0000_0200);
    rdchk(12'(asc_pkg::STATUS_IDX * 4), 32'h0000_0129);
  endtask : t_frontend

  task automatic t_hold_bypass;
    wr(setup_addr(2), 32'h0000_0000, 4'h3);
    fe_chk(fe_val(3'h2), 4'h0, 4'h0);
    apply(4'h9);
    fe_chk(16'h0000, 4'h0, 4'h0);
    wr(setup_addr(2), 32'h0000_000F, 4'h3);
    apply(4'h9);
    fe_chk(16'h000F, 4'h0, 4'h0);
  endtask : t_hold_bypass

  task automatic t_freeze;
    @(posedge pclk);
    pclk_en <= 1'b0;
    active_chan <= 4'h3;
    chan_change <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(pready, 32'h0);
    chan_change <= 1'b0;
    pclk_en <= 1'b1;
    @(negedge pclk);
    fe_chk(16'h000F, 4'h0, 4'h0);
    apply(4'h3);
    fe_chk(fe_val(3'h3), 4'h3, 4'hC);
  endtask : t_freeze

  task automatic t_mid_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    fe_chk(16'h0000, 4'h0, 4'h0);
    rdchk(setup_addr(2), 32'h0000_0000);
  endtask : t_mid_reset

  // ==================================================
  // verdict
  task automatic tally_and_finish;
    $display("checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // ==================================================
  // main sequence
  initial begin
    failures = 0;
    check_count = 0;
    presetn = 1'b0;
    pclk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    active_chan = 4'h0;
    chan_change = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_rw();
    t_err();
    t_frontend();
    t_hold_bypass();
    t_freeze();
    t_mid_reset();
    tally_and_finish();
  end
endmodule : adc_setup_config_bank_bench

`default_nettype wire
